// File: lane_err_defs.vh
// register map, field positions and reset values for the lane error hold block
// included by the design files; definitions only
`ifndef LANE_ERR_DEFS_VH
`define LANE_ERR_DEFS_VH

`define ADDR_W 12
`define DATA_W 8
`define CNT_W 8
`define LANE3_HOLD_ADDR 12'h48b
`define LANE4_HOLD_ADDR 12'h48c
`define LANE5_HOLD_ADDR 12'h48d
`define HOLD_W 3
`define HOLD_RESET 3'h7
`define BIT_UNEXP_CTRL 2
`define BIT_INVALID_CODE 1
`define BIT_DISPARITY 0
`define CNT_TERMINAL 8'hff
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01
`define RESERVED_ZERO 5'h00

`endif

// File: err_counter.v
// one 8-bit lane error counter with selectable saturation at terminal count
// assumes single clock, async active-high reset, synchronous clear
`timescale 1ns/100ps
`include "lane_err_defs.vh"

module err_counter (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire hold_en,
  input wire clear,
  input wire err,
  // count
  output reg [`CNT_W-1:0] count_q
);

  reg [`CNT_W-1:0] count_d;

  always @* begin
    count_d = count_q;
    if (clear) begin
      count_d = `CNT_ZERO;
    end else if (err) begin
      if (hold_en && count_q == `CNT_TERMINAL) begin
        count_d = count_q;
      end else begin
        count_d = count_q + `CNT_ONE;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= `CNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

endmodule // err_counter

// File: lane_error_count_hold.v
// hold-enable registers for lanes 3..5 and their three error counters each
// assumes a synchronous byte register port and error strobes synchronous to clk
`timescale 1ns/100ps
`include "lane_err_defs.vh"

module lane_error_count_hold (
  // clock and reset
  input wire clk,
  input wire rst,
  // configuration port
  input wire [`ADDR_W-1:0] cfg_addr,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [`DATA_W-1:0] cfg_wdata,
  output reg [`DATA_W-1:0] cfg_rdata_q,
  // error strobes, one bit per lane (bit 0 = lane 3)
  input wire [2:0] unexpected_control_char_error,
  input wire [2:0] invalid_code_error,
  input wire [2:0] running_disparity_error,
  // user clear of counters, per lane
  input wire [2:0] counter_clear,
  // counters, 8 bits per lane packed (lane 3 lowest)
  output wire [3*`CNT_W-1:0] unexp_ctrl_count_q,
  output wire [3*`CNT_W-1:0] invalid_code_count_q,
  output wire [3*`CNT_W-1:0] disparity_count_q
);

  // per-lane hold enables and their next values
  reg [`HOLD_W-1:0] lane3_saturate_enables_q;
  reg [`HOLD_W-1:0] lane4_saturate_enables_q;
  reg [`HOLD_W-1:0] lane5_saturate_enables_q;
  reg [`HOLD_W-1:0] lane3_saturate_enables_d;
  reg [`HOLD_W-1:0] lane4_saturate_enables_d;
  reg [`HOLD_W-1:0] lane5_saturate_enables_d;

  // read data next value
  reg [`DATA_W-1:0] cfg_rdata_d;

  // address decode
  wire lane3_sel;
  wire lane4_sel;
  wire lane5_sel;
  wire lane3_wr;
  wire lane4_wr;
  wire lane5_wr;

  // hold enable of each counter
  wire lane3_unexp_hold;
  wire lane3_invalid_hold;
  wire lane3_disp_hold;
  wire lane4_unexp_hold;
  wire lane4_invalid_hold;
  wire lane4_disp_hold;
  wire lane5_unexp_hold;
  wire lane5_invalid_hold;
  wire lane5_disp_hold;

  assign lane3_sel = (cfg_addr == `LANE3_HOLD_ADDR);
  assign lane4_sel = (cfg_addr == `LANE4_HOLD_ADDR);
  assign lane5_sel = (cfg_addr == `LANE5_HOLD_ADDR);
  // the write is accepted any time; keeping it to soft reset is software's job
  assign lane3_wr = cfg_wr && lane3_sel;
  assign lane4_wr = cfg_wr && lane4_sel;
  assign lane5_wr = cfg_wr && lane5_sel;

  // only bits 2:0 of the write data are stored
  always @* begin
    lane3_saturate_enables_d = lane3_saturate_enables_q;
    lane4_saturate_enables_d = lane4_saturate_enables_q;
    lane5_saturate_enables_d = lane5_saturate_enables_q;
    if (lane3_wr) begin
      lane3_saturate_enables_d = cfg_wdata[`HOLD_W-1:0];
    end
    if (lane4_wr) begin
      lane4_saturate_enables_d = cfg_wdata[`HOLD_W-1:0];
    end
    if (lane5_wr) begin
      lane5_saturate_enables_d = cfg_wdata[`HOLD_W-1:0];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lane3_saturate_enables_q <= `HOLD_RESET;
      lane4_saturate_enables_q <= `HOLD_RESET;
      lane5_saturate_enables_q <= `HOLD_RESET;
    end else begin
      lane3_saturate_enables_q <= lane3_saturate_enables_d;
      lane4_saturate_enables_q <= lane4_saturate_enables_d;
      lane5_saturate_enables_q <= lane5_saturate_enables_d;
    end
  end

  // reserved upper bits and unmapped addresses read zero
  always @* begin
    cfg_rdata_d = {`DATA_W{1'b0}};
    if (lane3_sel) begin
      cfg_rdata_d = {`RESERVED_ZERO, lane3_saturate_enables_q};
    end
    if (lane4_sel) begin
      cfg_rdata_d = {`RESERVED_ZERO, lane4_saturate_enables_q};
    end
    if (lane5_sel) begin
      cfg_rdata_d = {`RESERVED_ZERO, lane5_saturate_enables_q};
    end
  end

  // read data stands until the next read strobe
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata_q <= {`DATA_W{1'b0}};
    end else if (cfg_rd) begin
      cfg_rdata_q <= cfg_rdata_d;
    end
  end

  // one hold field per error type
  assign lane3_unexp_hold = lane3_saturate_enables_q[`BIT_UNEXP_CTRL];
  assign lane3_invalid_hold = lane3_saturate_enables_q[`BIT_INVALID_CODE];
  assign lane3_disp_hold = lane3_saturate_enables_q[`BIT_DISPARITY];
  assign lane4_unexp_hold = lane4_saturate_enables_q[`BIT_UNEXP_CTRL];
  assign lane4_invalid_hold = lane4_saturate_enables_q[`BIT_INVALID_CODE];
  assign lane4_disp_hold = lane4_saturate_enables_q[`BIT_DISPARITY];
  assign lane5_unexp_hold = lane5_saturate_enables_q[`BIT_UNEXP_CTRL];
  assign lane5_invalid_hold = lane5_saturate_enables_q[`BIT_INVALID_CODE];
  assign lane5_disp_hold = lane5_saturate_enables_q[`BIT_DISPARITY];

  // clear is per lane and beats an error in the same cycle
  // lane 3 counters
  err_counter lane3_unexp_counter (
    .clk(clk),
    .rst(rst),
    .hold_en(lane3_unexp_hold),
    .clear(counter_clear[0]),
    .err(unexpected_control_char_error[0]),
    .count_q(unexp_ctrl_count_q[0 +: `CNT_W])
  );

  err_counter lane3_invalid_counter (
    .clk(clk),
    .rst(rst),
    .hold_en(lane3_invalid_hold),
    .clear(counter_clear[0]),
    .err(invalid_code_error[0]),
    .count_q(invalid_code_count_q[0 +: `CNT_W])
  );

  err_counter lane3_disp_counter (
    .clk(clk),
    .rst(rst),
    .hold_en(lane3_disp_hold),
    .clear(counter_clear[0]),
    .err(running_disparity_error[0]),
    .count_q(disparity_count_q[0 +: `CNT_W])
  );

  // lane 4 counters
  err_counter lane4_unexp_counter (
    .clk(clk),
    .rst(rst),
    .hold_en(lane4_unexp_hold),
    .clear(counter_clear[1]),
    .err(unexpected_control_char_error[1]),
    .count_q(unexp_ctrl_count_q[`CNT_W +: `CNT_W])
  );

  err_counter lane4_invalid_counter (
    .clk(clk),
    .rst(rst),
    .hold_en(lane4_invalid_hold),
    .clear(counter_clear[1]),
    .err(invalid_code_error[1]),
    .count_q(invalid_code_count_q[`CNT_W +: `CNT_W])
  );

  err_counter lane4_disp_counter (
    .clk(clk),
    .rst(rst),
    .hold_en(lane4_disp_hold),
    .clear(counter_clear[1]),
    .err(running_disparity_error[1]),
    .count_q(disparity_count_q[`CNT_W +: `CNT_W])
  );

  // lane 5 counters
  err_counter lane5_unexp_counter (
    .clk(clk),
    .rst(rst),
    .hold_en(lane5_unexp_hold),
    .clear(counter_clear[2]),
    .err(unexpected_control_char_error[2]),
    .count_q(unexp_ctrl_count_q[2*`CNT_W +: `CNT_W])
  );

  err_counter lane5_invalid_counter (
    .clk(clk),
    .rst(rst),
    .hold_en(lane5_invalid_hold),
    .clear(counter_clear[2]),
    .err(invalid_code_error[2]),
    .count_q(invalid_code_count_q[2*`CNT_W +: `CNT_W])
  );

  err_counter lane5_disp_counter (
    .clk(clk),
    .rst(rst),
    .hold_en(lane5_disp_hold),
    .clear(counter_clear[2]),
    .err(running_disparity_error[2]),
    .count_q(disparity_count_q[2*`CNT_W +: `CNT_W])
  );

endmodule // lane_error_count_hold

// File: lane_hold_props.sv
// lane 3 counter and read port checks
// bound into lane_error_count_hold by port names
`timescale 1ns/100ps
module lane_hold_props (
  input wire clk, rst, cfg_rd, cfg_wr,
  input wire [11:0] cfg_addr,
  input wire [7:0] cfg_wdata, cfg_rdata_q,
  input wire [2:0] running_disparity_error, counter_clear,
  input wire [23:0] disparity_count_q
);
  wire [7:0] d = disparity_count_q[7:0];
  wire e = running_disparity_error[0];
  wire c = counter_clear[0];
  reg [2:0] hold_q;
  // shadow of the lane 3 hold field
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q <= 3'h7;
    end else if (cfg_wr && cfg_addr == 12'h48b) begin
      hold_q <= cfg_wdata[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  count_step_a: assert property (!c && e && d != 8'hff |=> d == $past(d) + 8'h01)
    else $error("no step");
  count_idle_a: assert property (!c && !e |=> $stable(d)) else $error("moved");
  count_clear_a: assert property (c |=> d == 8'h00) else $error("no clear");
  top_value_a: assert property (!c && e && d == 8'hff |=> d == 8'hff || d == 8'h00)
    else $error("bad top");
  hold_top_a: assert property (!c && e && d == 8'hff && hold_q[0] |=> d == 8'hff)
    else $error("no hold at top");
  wrap_top_a: assert property (!c && e && d == 8'hff && !hold_q[0] |=> d == 8'h00)
    else $error("no wrap at top");
  reserved_zero_a: assert property (cfg_rd |=> cfg_rdata_q[7:3] == 5'h00)
    else $error("reserved set");
  cover property (c);
  cover property (e && d == 8'hff);
  cover property (cfg_rd);
endmodule // lane_hold_props
bind lane_error_count_hold lane_hold_props lane_hold_props_inst (.clk(clk), .rst(rst),
  .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
  .cfg_rdata_q(cfg_rdata_q), .running_disparity_error(running_disparity_error),
  .counter_clear(counter_clear), .disparity_count_q(disparity_count_q));

// File: link_tx.sv
// serial transmitter stand-in raising error strobes
// strobes follow the request one clock later
`timescale 1ns/100ps
module link_tx (
  input wire clk,
  input wire [8:0] burst,
  output reg [8:0] err_q
);
  always @(posedge clk) begin
    err_q <= burst;
  end
endmodule // link_tx

// File: lane_error_count_hold_bench.sv
// bench for lane_error_count_hold
// drives the config port and a link_tx stand-in
`timescale 1ns/100ps
module lane_error_count_hold_bench;
  reg clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0;
  reg [11:0] cfg_addr = 12'h000;
  reg [7:0] cfg_wdata = 8'h00;
  reg [2:0] counter_clear = 3'h0;
  reg [8:0] burst = 9'h000;
  wire [8:0] err;
  wire [7:0] rdq;
  wire [23:0] uc, ic, dc;
  integer bad_count = 0, samples_checked = 0, cyc = 0, l, b;
  reg [7:0] hold [0:2];
  always #25 clk = ~clk;
  link_tx link_tx_inst (.clk(clk), .burst(burst), .err_q(err));
  lane_error_count_hold lane_error_count_hold_inst (.clk(clk), .rst(rst), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata_q(rdq),
    .unexpected_control_char_error(err[8:6]), .invalid_code_error(err[5:3]),
    .running_disparity_error(err[2:0]), .counter_clear(counter_clear),
    .unexp_ctrl_count_q(uc), .invalid_code_count_q(ic), .disparity_count_q(dc));
  task chk(input string n, input [7:0] x, input [7:0] g);
    samples_checked = samples_checked + 1;
    if (g !== x) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s exp %h got %h", n, x, g);
    end
  endtask
  task wr(input [11:0] a, input [7:0] v);
    @(posedge clk);
    cfg_addr <= a;
    cfg_wdata <= v;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  task rd(input [11:0] a, input [7:0] x);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    @(posedge clk);
    #1 chk("rdata", x, rdq);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
  initial begin
    hold[0] = 8'h01;
    hold[1] = 8'h02;
    hold[2] = 8'h07;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (l = 0; l < 3; l = l + 1) rd(12'h48b + l[11:0], 8'h07);
    rd(12'h48a, 8'h00);
    $display("test reset done");
    wr(12'h48b, 8'h01);
    wr(12'h48c, 8'hfa);
    rd(12'h48c, 8'h02);
    $display("test config done");
    @(posedge clk);
    burst <= 9'h1ff;
    repeat (256) @(posedge clk);
    burst <= 9'h000;
    repeat (3) @(posedge clk);
    #1;
    for (l = 0; l < 3; l = l + 1)
      for (b = 0; b < 3; b = b + 1)
        chk("count", hold[l][b] ? 8'hff : 8'h00,
          b == 2 ? uc[8*l+:8] : b == 1 ? ic[8*l+:8] : dc[8*l+:8]);
    $display("test saturate done");
    @(posedge clk);
    counter_clear <= 3'h7;
    @(posedge clk);
    counter_clear <= 3'h0;
    @(posedge clk);
    #1;
    for (l = 0; l < 3; l = l + 1)
      chk("clear", 8'h00, uc[8*l+:8] | ic[8*l+:8] | dc[8*l+:8]);
    $display("test clear done");
    wr(12'h48b, 8'h00);
    rd(12'h48b, 8'h00);
    @(posedge clk);
    burst <= 9'h001;
    repeat (255) @(posedge clk);
    burst <= 9'h000;
    repeat (3) @(posedge clk);
    #1 chk("wrap top", 8'hff, dc[7:0]);
    @(posedge clk);
    burst <= 9'h001;
    @(posedge clk);
    burst <= 9'h000;
    repeat (3) @(posedge clk);
    #1 chk("wrap", 8'h00, dc[7:0]);
    $display("test wrap done");
    summarize;
  end
endmodule // lane_error_count_hold_bench
